// *** logic/sgo_axil_slave.sv ***
module sgo_axil_slave (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [`SGO_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`SGO_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`SGO_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [`SGO_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [`SGO_AW-1:0] wr_addr,
	output logic [`SGO_DW-1:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic [`SGO_AW-1:0] rd_addr,
	input wire logic [`SGO_DW-1:0] rd_data,
	input wire logic rd_ok
);

	logic aw_held_reg;
	logic w_held_reg;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic aw_held_next;
	logic w_held_next;
	logic rvalid_next;

	// Handshakes and holding state
	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs = s_axi_wvalid & s_axi_wready;
	assign ar_hs = s_axi_arvalid & s_axi_arready;
	assign wr_en = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	assign aw_held_next = (aw_held_reg | aw_hs) & ~wr_en;
	assign w_held_next = (w_held_reg | w_hs) & ~wr_en;
	assign rvalid_next = (s_axi_rvalid & ~s_axi_rready) | ar_hs;
	assign rd_addr = s_axi_araddr;

	// Write address and data, either order
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= 4'h0;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			s_axi_awready <= ~aw_held_next;
			s_axi_wready <= ~w_held_next;
			if (aw_hs)
				wr_addr <= s_axi_awaddr;
			if (w_hs) begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
		end
	end

	// Write response
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (wr_en) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
		end else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Read channel, data captured at address handshake
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= ~rvalid_next;
			s_axi_rvalid <= rvalid_next;
			if (ar_hs) begin
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
			end
		end
	end

endmodule : sgo_axil_slave

// *** logic/sgo_event_log.sv ***
module sgo_event_log import sgo_pkg::*; (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire sgo_log_entry_t wr_entry,
	input wire logic [3:0] rd_idx,
	output sgo_log_entry_t rd_entry,
	output logic [3:0] count
);

	sgo_log_entry_t mem_reg [`SGO_LOG_DEPTH];
	logic [3:0] wptr_reg;
	logic [3:0] count_reg;
	logic [3:0] slot;

	// Ring write, oldest overwritten
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wptr_reg <= 4'h0;
			count_reg <= 4'h0;
		end else if (wr_en) begin
			wptr_reg <= (wptr_reg == 4'(`SGO_LOG_DEPTH - 1)) ? 4'h0 : wptr_reg + 4'h1;
			if (count_reg != 4'(`SGO_LOG_DEPTH))
				count_reg <= count_reg + 4'h1;
		end
	end

	// Storage array, no reset needed
	always_ff @(posedge core_clk) begin
		if (wr_en)
			mem_reg[wptr_reg] <= wr_entry;
	end

	// Index 0 is the newest record
	always_comb begin
		slot = (wptr_reg > rd_idx) ? wptr_reg - rd_idx - 4'h1 : 4'(`SGO_LOG_DEPTH) + wptr_reg - rd_idx - 4'h1;
		rd_entry = (rd_idx < count_reg) ? mem_reg[slot] : '0;
	end

	assign count = count_reg;

endmodule : sgo_event_log

// *** logic/sgo_object_control.sv ***
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
module sgo_object_control import sgo_pkg::*; #(
	parameter int unsigned TICK_DIV = `SGO_TICK_DIV
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [`SGO_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`SGO_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`SGO_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [`SGO_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire sgo_cmd_t cmd_in,
	input wire sgo_block_t block_in,
	input wire logic pos_open_in,
	input wire logic pos_closed_in,
	input wire logic ready_in,
	input wire logic reclose_expected_in,
	output logic close_cmd_out,
	output logic open_cmd_out,
	output logic final_trip_out,
	output sgo_pos_t position_out,
	output logic ctrl_error_out
);

	// Settings and control registers
	logic [31:0] ctrl_reg;
	logic [31:0] traverse_reg;
	logic [31:0] close_pulse_reg;
	logic [31:0] open_pulse_reg;
	logic [31:0] timeout_reg;
	logic [31:0] final_trip_reg;
	logic [31:0] evt_mask_reg;
	logic [3:0] log_sel_reg;

	// Timebase
	logic [31:0] div_reg;
	logic tick_reg;
	logic [31:0] time_reg;

	// Position and sequence state
	logic [1:0] stat_prev_reg;
	logic [31:0] trav_cnt_reg;
	sgo_pos_t pos_next;
	sgo_state_t state_reg;
	logic [31:0] seq_cnt_reg;
	logic [31:0] ft_cnt_reg;
	sgo_cmd_t cmd_prev_reg;
	logic disp_close_reg;
	logic disp_open_reg;
	logic disp_fail_reg;
	logic open_fail_reg;
	logic close_fail_reg;
	logic open_req_reg;
	logic close_req_reg;
	logic [`SGO_EV_N-1:0] ev_prev_reg;

	// Combinational terms
	sgo_cmd_t cmd_rise;
	logic close_req;
	logic open_req;
	logic close_blocked;
	logic open_blocked;
	logic ready_ok;
	logic trav_done;
	logic open_done;
	logic close_done;
	logic timeout_hit;
	logic [`SGO_EV_N-1:0] ev_now;
	logic [`SGO_EV_N-1:0] ev_rec;
	sgo_log_entry_t log_wr;
	sgo_log_entry_t log_rd;
	logic [3:0] log_count;

	// Bus slave side
	logic wr_en;
	logic [`SGO_AW-1:0] wr_addr;
	logic [`SGO_DW-1:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic [`SGO_AW-1:0] rd_addr;
	logic [`SGO_DW-1:0] rd_data;
	logic rd_ok;

	// Byte-lane merge of a register write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		end
		return res;
	endfunction : merge

	// True for an address software may write
	function automatic logic is_writable(input logic [`SGO_AW-1:0] a);
		logic ok;
		if (a == `SGO_A_CTRL)
			ok = 1'b1;
		else if (a == `SGO_A_TRAVERSE || a == `SGO_A_CLOSE_PULSE || a == `SGO_A_OPEN_PULSE)
			ok = 1'b1;
		else if (a == `SGO_A_TIMEOUT || a == `SGO_A_FINAL_TRIP)
			ok = 1'b1;
		else if (a == `SGO_A_DISPLAY_CMD || a == `SGO_A_EVT_MASK || a == `SGO_A_LOG_SEL)
			ok = 1'b1;
		else
			ok = 1'b0;
		return ok;
	endfunction : is_writable

	sgo_axil_slave u_bus (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	assign wr_ok = is_writable(wr_addr);

	// Register writes
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= `SGO_CTRL_RST;
			traverse_reg <= 32'(`SGO_TRAVERSE_MS);
			close_pulse_reg <= 32'(`SGO_CLOSE_PULSE_MS);
			open_pulse_reg <= 32'(`SGO_OPEN_PULSE_MS);
			timeout_reg <= 32'(`SGO_TIMEOUT_MS);
			final_trip_reg <= 32'(`SGO_FINAL_TRIP_MS);
			evt_mask_reg <= `SGO_EVT_MASK_RST;
			log_sel_reg <= 4'h0;
		end else if (wr_en) begin
			if (wr_addr == `SGO_A_CTRL)
				ctrl_reg <= merge(ctrl_reg, wr_data, wr_strb) & 32'h0000_000F;
			else if (wr_addr == `SGO_A_TRAVERSE)
				traverse_reg <= merge(traverse_reg, wr_data, wr_strb);
			else if (wr_addr == `SGO_A_CLOSE_PULSE)
				close_pulse_reg <= merge(close_pulse_reg, wr_data, wr_strb);
			else if (wr_addr == `SGO_A_OPEN_PULSE)
				open_pulse_reg <= merge(open_pulse_reg, wr_data, wr_strb);
			else if (wr_addr == `SGO_A_TIMEOUT)
				timeout_reg <= merge(timeout_reg, wr_data, wr_strb);
			else if (wr_addr == `SGO_A_FINAL_TRIP)
				final_trip_reg <= merge(final_trip_reg, wr_data, wr_strb);
			else if (wr_addr == `SGO_A_EVT_MASK)
				evt_mask_reg <= merge(evt_mask_reg, wr_data, wr_strb);
			else if (wr_addr == `SGO_A_LOG_SEL && wr_strb[0])
				log_sel_reg <= wr_data[3:0];
		end
	end

	// Display command: caller level must reach required level
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			disp_close_reg <= 1'b0;
			disp_open_reg <= 1'b0;
			disp_fail_reg <= 1'b0;
		end else begin
			disp_close_reg <= 1'b0;
			disp_open_reg <= 1'b0;
			disp_fail_reg <= 1'b0;
			if (wr_en && wr_addr == `SGO_A_DISPLAY_CMD && wr_strb[0]) begin
				if (wr_data[5:4] >= ctrl_reg[1:0]) begin
					disp_close_reg <= wr_data[0];
					disp_open_reg <= wr_data[1];
				end else
					disp_fail_reg <= |wr_data[1:0];
			end
		end
	end

	// Register reads
	always_comb begin
		rd_ok = 1'b1;
		rd_data = '0;
		if (rd_addr == `SGO_A_CTRL)
			rd_data = ctrl_reg;
		else if (rd_addr == `SGO_A_TRAVERSE)
			rd_data = traverse_reg;
		else if (rd_addr == `SGO_A_CLOSE_PULSE)
			rd_data = close_pulse_reg;
		else if (rd_addr == `SGO_A_OPEN_PULSE)
			rd_data = open_pulse_reg;
		else if (rd_addr == `SGO_A_TIMEOUT)
			rd_data = timeout_reg;
		else if (rd_addr == `SGO_A_FINAL_TRIP)
			rd_data = final_trip_reg;
		else if (rd_addr == `SGO_A_STATUS)
			rd_data = {18'h00000, log_count, 1'b0, ctrl_error_out, final_trip_out, open_cmd_out,
				close_cmd_out, state_reg, position_out};
		else if (rd_addr == `SGO_A_DISPLAY_CMD)
			rd_data = '0;
		else if (rd_addr == `SGO_A_EVT_MASK)
			rd_data = evt_mask_reg;
		else if (rd_addr == `SGO_A_LOG_SEL)
			rd_data = {28'h0000000, log_sel_reg};
		else if (rd_addr == `SGO_A_LOG_EVT)
			rd_data = {log_rd.changed, log_rd.values};
		else if (rd_addr == `SGO_A_LOG_TS)
			rd_data = log_rd.stamp;
		else if (rd_addr == `SGO_A_TIME)
			rd_data = time_reg;
		else
			rd_ok = 1'b0;
	end

	// Millisecond tick and time stamp counter
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg <= '0;
			tick_reg <= 1'b0;
			time_reg <= '0;
		end else begin
			tick_reg <= (div_reg == TICK_DIV - 1);
			div_reg <= (div_reg == TICK_DIV - 1) ? '0 : div_reg + 32'h1;
			if (tick_reg)
				time_reg <= time_reg + 32'h1;
		end
	end

	// Traverse timer restarts on any status input change
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stat_prev_reg <= 2'h0;
			trav_cnt_reg <= '0;
		end else begin
			stat_prev_reg <= {pos_open_in, pos_closed_in};
			if (stat_prev_reg != {pos_open_in, pos_closed_in})
				trav_cnt_reg <= '0;
			else if (tick_reg && !trav_done)
				trav_cnt_reg <= trav_cnt_reg + 32'h1;
		end
	end

	// Done only while the inputs hold steady, so a change never flashes a stale result
	assign trav_done = (trav_cnt_reg >= traverse_reg) && (stat_prev_reg == {pos_open_in, pos_closed_in});

	// Position classification from the two inputs
	always_comb begin
		case ({pos_open_in, pos_closed_in})
			2'b10: pos_next = POS_OPEN;
			2'b01: pos_next = POS_CLOSED;
			2'b11: pos_next = trav_done ? POS_BAD : POS_MOVING;
			default: pos_next = trav_done ? POS_INTER : POS_MOVING;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			position_out <= POS_MOVING;
		else
			position_out <= pos_next;
	end

	// Command requests from every source, rising edges only
	assign cmd_rise = cmd_in & ~cmd_prev_reg;
	assign close_req = cmd_rise.local_close | cmd_rise.remote_close | cmd_rise.app_close | disp_close_reg;
	assign open_req = cmd_rise.local_open | cmd_rise.remote_open | cmd_rise.app_open | disp_open_reg;
	assign close_blocked = block_in.close_block | block_in.close_ilock;
	assign open_blocked = block_in.open_block | block_in.open_ilock;
	assign ready_ok = (ctrl_reg[3:2] == 2'h0) ? ready_in : (ctrl_reg[3:2] == 2'h1) ? ~ready_in : 1'b1;

	// Sequence ending conditions
	assign close_done = (state_reg == ST_CLOSING) && pos_closed_in && !pos_open_in;
	assign open_done = (state_reg == ST_OPENING) && pos_open_in && !pos_closed_in;
	assign timeout_hit = (state_reg != ST_IDLE) && (seq_cnt_reg >= timeout_reg);

	// Control sequence: pulse out, wait for position, time out
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			seq_cnt_reg <= '0;
			close_cmd_out <= 1'b0;
			open_cmd_out <= 1'b0;
			ctrl_error_out <= 1'b0;
			open_fail_reg <= 1'b0;
			close_fail_reg <= 1'b0;
			open_req_reg <= 1'b0;
			close_req_reg <= 1'b0;
			cmd_prev_reg <= '0;
		end else begin
			cmd_prev_reg <= cmd_in;
			ctrl_error_out <= 1'b0;
			open_fail_reg <= 1'b0;
			close_fail_reg <= disp_fail_reg;
			open_req_reg <= open_req;
			close_req_reg <= close_req;
			if (tick_reg)
				seq_cnt_reg <= seq_cnt_reg + 32'h1;
			case (state_reg)
				ST_IDLE: begin
					// Block sampled when the command edge arrives
					if (open_req) begin
						if (open_blocked)
							open_fail_reg <= 1'b1;
						else begin
							state_reg <= ST_OPENING;
							open_cmd_out <= 1'b1;
							seq_cnt_reg <= '0;
						end
					end else if (close_req) begin
						if (close_blocked || !ready_ok)
							close_fail_reg <= 1'b1;
						else begin
							state_reg <= ST_CLOSING;
							close_cmd_out <= 1'b1;
							seq_cnt_reg <= '0;
						end
					end
				end
				default: begin
					// Requests ignored until the sequence ends
					if (close_done || open_done) begin
						state_reg <= ST_IDLE;
						close_cmd_out <= 1'b0;
						open_cmd_out <= 1'b0;
					end else if (timeout_hit) begin
						state_reg <= ST_IDLE;
						close_cmd_out <= 1'b0;
						open_cmd_out <= 1'b0;
						ctrl_error_out <= 1'b1;
					end else begin
						if (seq_cnt_reg >= close_pulse_reg)
							close_cmd_out <= 1'b0;
						if (seq_cnt_reg >= open_pulse_reg)
							open_cmd_out <= 1'b0;
					end
				end
			endcase
		end
	end

	// Final trip after a completed open
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			final_trip_out <= 1'b0;
			ft_cnt_reg <= '0;
		end else if (open_done && !reclose_expected_in) begin
			final_trip_out <= 1'b1;
			ft_cnt_reg <= '0;
		end else if (state_reg == ST_CLOSING)
			final_trip_out <= 1'b0;
		else if (final_trip_out && final_trip_reg != 32'h0) begin
			if (ft_cnt_reg >= final_trip_reg)
				final_trip_out <= 1'b0;
			else if (tick_reg)
				ft_cnt_reg <= ft_cnt_reg + 32'h1;
		end
	end

	// Monitored event vector
	assign ev_now = {1'b0, close_req_reg, open_req_reg, ctrl_error_out, close_fail_reg, open_fail_reg,
		final_trip_out, ready_in, close_blocked, open_blocked, close_cmd_out, open_cmd_out,
		position_out == POS_INTER, position_out == POS_BAD, position_out == POS_CLOSED,
		position_out == POS_OPEN};

	// Per-bit ON and OFF selection
	for (genvar i = 0; i < `SGO_EV_N; i++) begin : g_ev
		assign ev_rec[i] = (ev_now[i] & ~ev_prev_reg[i] & evt_mask_reg[i])
			| (~ev_now[i] & ev_prev_reg[i] & evt_mask_reg[i + `SGO_EV_N]);
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			ev_prev_reg <= '0;
		else
			ev_prev_reg <= ev_now;
	end

	// Time stamp and snapshot of all monitored values
	assign log_wr = '{stamp: time_reg, changed: ev_rec, values: ev_now};

	sgo_event_log u_log (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.wr_en(|ev_rec),
		.wr_entry(log_wr),
		.rd_idx(log_sel_reg),
		.rd_entry(log_rd),
		.count(log_count)
	);

endmodule : sgo_object_control

// *** logic/sgo_params.svh ***
`ifndef SGO_PARAMS_SVH
`define SGO_PARAMS_SVH

// Clock and millisecond tick
`define SGO_CLK_HZ 100000000
`define SGO_TICK_US 1000
`define SGO_TICK_DIV ((`SGO_CLK_HZ / 1000000) * `SGO_TICK_US)

// Setting defaults in milliseconds
`define SGO_TRAVERSE_MS 200
`define SGO_CLOSE_PULSE_MS 200
`define SGO_OPEN_PULSE_MS 200
`define SGO_TIMEOUT_MS 10000
`define SGO_FINAL_TRIP_MS 200

// Bus geometry
`define SGO_AW 8
`define SGO_DW 32
`define SGO_LOG_DEPTH 12
`define SGO_EV_N 16

// Register byte addresses
`define SGO_A_CTRL 8'h00
`define SGO_A_TRAVERSE 8'h04
`define SGO_A_CLOSE_PULSE 8'h08
`define SGO_A_OPEN_PULSE 8'h0C
`define SGO_A_TIMEOUT 8'h10
`define SGO_A_FINAL_TRIP 8'h14
`define SGO_A_STATUS 8'h18
`define SGO_A_DISPLAY_CMD 8'h1C
`define SGO_A_EVT_MASK 8'h20
`define SGO_A_LOG_SEL 8'h24
`define SGO_A_LOG_EVT 8'h28
`define SGO_A_LOG_TS 8'h2C
`define SGO_A_TIME 8'h30

// Control register reset value: level 2, ready check off (2)
`define SGO_CTRL_RST 32'h0000_000A
`define SGO_EVT_MASK_RST 32'hFFFF_FFFF

// Event vector bit positions
`define SGO_EV_POS_OPEN 0
`define SGO_EV_POS_CLOSED 1
`define SGO_EV_POS_BAD 2
`define SGO_EV_POS_INTER 3
`define SGO_EV_OPEN_CMD 4
`define SGO_EV_CLOSE_CMD 5
`define SGO_EV_OPEN_BLK 6
`define SGO_EV_CLOSE_BLK 7
`define SGO_EV_READY 8
`define SGO_EV_FINAL 9
`define SGO_EV_OPEN_FAIL 10
`define SGO_EV_CLOSE_FAIL 11
`define SGO_EV_TIMEOUT 12
`define SGO_EV_OPEN_REQ 13
`define SGO_EV_CLOSE_REQ 14

`endif

// *** logic/sgo_pkg.sv ***
`include "sgo_params.svh"

package sgo_pkg;

	// Classified object position
	typedef enum logic [2:0] {
		POS_MOVING,
		POS_OPEN,
		POS_CLOSED,
		POS_INTER,
		POS_BAD
	} sgo_pos_t;

	// Control sequence state
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CLOSING,
		ST_OPENING
	} sgo_state_t;

	// Command sources
	typedef struct packed {
		logic local_close;
		logic local_open;
		logic remote_close;
		logic remote_open;
		logic app_close;
		logic app_open;
	} sgo_cmd_t;

	// Blocking and interlock conditions
	typedef struct packed {
		logic open_block;
		logic open_ilock;
		logic close_block;
		logic close_ilock;
	} sgo_block_t;

	// One record of the event log
	typedef struct packed {
		logic [31:0] stamp;
		logic [`SGO_EV_N-1:0] changed;
		logic [`SGO_EV_N-1:0] values;
	} sgo_log_entry_t;

endpackage : sgo_pkg

// *** test/sgo_object_control_asserts.sv ***
module sgo_object_control_checker import sgo_pkg::*; (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire sgo_block_t block_in,
	input wire logic pos_open_in,
	input wire logic pos_closed_in,
	input wire logic reclose_expected_in,
	input wire logic close_cmd_out,
	input wire logic open_cmd_out,
	input wire logic final_trip_out,
	input wire sgo_pos_t position_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	// Object resting at one end
	sequence s_open;
		pos_open_in && !pos_closed_in;
	endsequence
	sequence s_closed;
		pos_closed_in && !pos_open_in;
	endsequence
	a_close_reached: assert property (close_cmd_out ##0 s_closed |=> !close_cmd_out)
		else $error("close pulse overran");
	a_open_reached: assert property (open_cmd_out ##0 s_open |=> !open_cmd_out)
		else $error("open pulse overran");
	a_show_open: assert property (s_open |=> position_out == POS_OPEN)
		else $error("open not shown");
	a_bad_both: assert property (position_out == POS_BAD |-> $past(pos_open_in) && $past(pos_closed_in))
		else $error("bad without both");
	a_inter_none: assert property (position_out == POS_INTER |-> !$past(pos_open_in) && !$past(pos_closed_in))
		else $error("intermediate with input");
	a_close_gate: assert property ($rose(close_cmd_out) |-> !$past(block_in.close_block) && !$past(block_in.close_ilock))
		else $error("blocked close ran");
	a_one_relay: assert property (!(close_cmd_out && open_cmd_out))
		else $error("both relays");
	a_final_gate: assert property ($rose(final_trip_out) |-> !$past(reclose_expected_in))
		else $error("final trip with reclose");
endmodule : sgo_object_control_checker

bind sgo_object_control sgo_object_control_checker u_chk (.*);

// *** test/sgo_switch_model.sv ***
module sgo_switch_model (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic close_cmd_out,
	input wire logic open_cmd_out,
	input wire logic [1:0] mode,
	output logic pos_open_in,
	output logic pos_closed_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic closed_reg;
	logic [5:0] travel_reg;

	// Travel: mode 1 slow, mode 2 jams short
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			closed_reg <= 1'b0;
			travel_reg <= 6'h00;
		end else if (travel_reg != 6'h00) begin
			if (mode != 2'h2 || travel_reg != 6'h01) travel_reg <= travel_reg - 6'h01;
			if (mode != 2'h2 && travel_reg == 6'h01) closed_reg <= !closed_reg;
		end else if ((close_cmd_out && !closed_reg) || (open_cmd_out && closed_reg)) begin
			travel_reg <= (mode == 2'h1) ? 6'h28 : 6'h04;
		end
	end
	// Contacts open in travel; mode 3 makes both
	assign pos_open_in = mode == 2'h3 || (!closed_reg && travel_reg == 6'h00);
	assign pos_closed_in = mode == 2'h3 || (closed_reg && travel_reg == 6'h00);
endmodule : sgo_switch_model

// *** test/tb_top.sv ***
module tb_top import sgo_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] SV [6] = '{32'h2, 32'h2, 32'h3, 32'h3, 32'h8, 32'h2};
	logic core_clk = 1'b0, arst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, mode = 2'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic pos_open_in, pos_closed_in, ready_in = 1'b1, reclose_expected_in = 1'b0;
	logic close_cmd_out, open_cmd_out, final_trip_out, ctrl_error_out;
	sgo_cmd_t cmd_in = 6'h00;
	sgo_block_t block_in = 4'h0;
	sgo_pos_t position_out;
	int n_errors = 0, num_checks = 0, len;

	// Ten-cycle tick
	sgo_object_control #(.TICK_DIV(10)) uut (.*);
	sgo_switch_model u_obj (.*);
	always #5 core_clk = ~core_clk;

	// Compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic ok(input string n, input logic c);
		chk(n, 32'h1, {31'h0, c});
	endtask : ok
	// Bus write, each channel held until taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
	endtask : wr
	// Bus read
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd
	// Relay pulse length after a request
	task automatic watch(output int n);
		n = 0;
		for (int i = 0; i < 60; i++) begin
			@(posedge core_clk);
			if (close_cmd_out === 1'b1 || open_cmd_out === 1'b1) n++;
			else if (n > 0 || i > 3) break;
		end
	endtask : watch
	task automatic cmd(input int b, output int n);
		@(posedge core_clk);
		cmd_in[b] <= 1'b1;
		@(posedge core_clk);
		cmd_in[b] <= 1'b0;
		watch(n);
	endtask : cmd
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	// Hang guard
	initial begin
		#100us;
		n_errors++;
		summarize();
	end

	// Main sequence
	initial begin
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		rd(8'h00);
		chk("ctrl reset", 32'hA, d);
		rd(8'h10);
		chk("timeout reset", 32'h2710, d);
		for (int i = 0; i < 6; i++) wr(8'(4 * i), SV[i], 2'h0);
		rd(8'h40);
		chk("unmapped", 32'h2, {30'h0, r});
		wr(8'h18, 32'h0, 2'h2);
		cmd(5, len);
		ok("quick close", len > 0 && len < 20);
		ok("closed", position_out === POS_CLOSED);
		cmd(2, len);
		repeat (3) @(posedge core_clk);
		ok("final on", final_trip_out === 1'b1);
		repeat (35) @(posedge core_clk);
		ok("final off", final_trip_out === 1'b0);
		wr(8'h1C, 32'h11, 2'h0);
		watch(len);
		ok("low level", len == 0);
		wr(8'h1C, 32'h31, 2'h0);
		watch(len);
		ok("display close", len > 0);
		reclose_expected_in <= 1'b1;
		cmd(4, len);
		repeat (3) @(posedge core_clk);
		ok("final held", final_trip_out === 1'b0);
		ready_in <= 1'b0;
		cmd(1, len);
		ok("not ready", len == 0);
		ready_in <= 1'b1;
		mode <= 2'h1;
		cmd(1, len);
		ok("close cap", len > 21 && len < 32);
		repeat (30) @(posedge core_clk);
		// Interlock raised well ahead
		block_in <= 4'h4;
		repeat (60) @(posedge core_clk);
		cmd(2, len);
		ok("interlocked", len == 0);
		block_in <= 4'h0;
		// Jammed object
		mode <= 2'h2;
		cmd(0, len);
		ok("open cap", len > 21 && len < 32);
		cmd(5, len);
		ok("busy", len == 0);
		for (int i = 0; i < 100 && ctrl_error_out !== 1'b1; i++) @(posedge core_clk);
		ok("timeout", ctrl_error_out === 1'b1);
		ok("inter", position_out === POS_INTER);
		mode <= 2'h3;
		repeat (45) @(posedge core_clk);
		ok("bad", position_out === POS_BAD);
		rd(8'h18);
		chk("log count", 32'hC, {28'h0, d[13:10]});
		// Newest record: bad position rose, ready still high
		rd(8'h28);
		chk("log event", 32'h0004_0104, d);
		summarize();
	end
endmodule : tb_top
